// >>> dv/oc_far_side.sv
// far-side model of the compare channel: timer clock sources and fault pins
`timescale 1ns/100ps
module oc_far_side (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] run,
  input wire logic [2:0] flt,
  output logic [4:0] tclk,
  output logic [2:0] fpin
);
  logic [1:0] div;

  // ----------------------------------------
  // timer clock sources
  // ----------------------------------------
  // a stopped source stands low, so it shows no rising edge to count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 2'h0;
      tclk <= 5'h00;
    end else begin
      div <= div + 2'h1;
      tclk <= (div == 2'h0) ? (~tclk & run) : (tclk & run);
    end
  end

  // ----------------------------------------
  // fault pins, active-high levels
  // ----------------------------------------
  assign fpin = flt;
endmodule : oc_far_side

// >>> dv/tb_top.sv
// self-checking bench of the compare channel control block
`timescale 1ns/100ps
`include "oc_map.svh"
module tb_top;
  typedef struct packed {
    logic err;
    logic inv;
    logic [31:0] mask;
    logic [31:0] val;
  } note_t;
  logic clk, nrst, psel, penable, pwrite, cpu_idle, pready, pslverr, irq, compare_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] run, tclk;
  logic [2:0] flt, fpin;
  logic [15:0] lfsr;
  logic [4:0] stop;
  int failures, cmp_count, high_cnt;
  note_t notes[$];
  note_t n;

  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  output_compare_control dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .cpu_idle(cpu_idle), .timer1_clock_source(tclk[0]), .timer2_clock_source(tclk[1]),
    .timer3_clock_source(tclk[2]), .timer4_clock_source(tclk[3]), .timer5_clock_source(tclk[4]),
    .fault_a_pin(fpin[0]), .fault_b_pin(fpin[1]), .fault_c_pin(fpin[2]), .compare_out(compare_out));
  oc_far_side far (.clk(clk), .nrst(nrst), .run(run), .flt(flt), .tclk(tclk), .fpin(fpin));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no cycle count assumed; only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v, input logic e, input logic i);
    notes.push_back('{e, i, m, v});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    notes.push_back('{1'b0, 1'b0, 32'h0, 32'h0});
    apb(1'b1, a, d);
  endtask : wr

  task automatic wait_clk(input int c);
    repeat (c) @(posedge clk);
  endtask : wait_clk

  task automatic count_high(input int c, output int h);
    h = 0;
    repeat (c) begin
      @(posedge clk);
      h += int'(compare_out);
    end
  endtask : count_high

  // ----------------------------------------
  // answer monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected answer", 32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        check("pslverr", {31'h0, pslverr}, {31'h0, n.err});
        if (n.inv) check("timer advanced", {31'h0, (prdata & n.mask) !== n.val}, 32'h1);
        else check("prdata", prdata & n.mask, n.val);
      end
    end
  end

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 20000);
    failures++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpu_idle = 1'b0;
    run = 5'h00;
    flt = 3'h0;
    lfsr = 16'h002f;
    failures = 0;
    cmp_count = 0;
    wait_clk(16);
    nrst <= 1'b1;
    rd(`OC_ADDR_CON1, 32'hffff_ffff, 32'h0, 1'b0, 1'b0);
    rd(`OC_ADDR_ISTAT, 32'hffff_ffff, 32'h0, 1'b0, 1'b0);
    wr(`OC_ADDR_CON1, 32'h0000_dc00);
    rd(`OC_ADDR_CON1, 32'hffff_ffff, 32'h0000_1c00, 1'b0, 1'b0);
    rd(12'h01c, 32'hffff_ffff, 32'h0, 1'b1, 1'b0);
    // every select: selects 0 to 4 stop only their source, 5 to 7 stop none, then run all sources
    for (int s = 0; s < 8; s++) begin
      stop = (s == 4) ? 5'h01 : (s < 4) ? (5'h02 << s) : 5'h00;
      run <= 5'h1f & ~stop;
      lfsr = lfsr_next(lfsr);
      wr(`OC_ADDR_CON1, {19'h0, s[2:0], 10'h0});
      wr(`OC_ADDR_TMR, {16'h0, lfsr});
      wait_clk(40);
      rd(`OC_ADDR_TMR, 32'h0000_ffff, {16'h0, lfsr}, 1'b0, s == 7);
      run <= 5'h1f;
      wait_clk(40);
      rd(`OC_ADDR_TMR, 32'h0000_ffff, {16'h0, lfsr}, 1'b0, s != 5 && s != 6);
    end
    cpu_idle <= 1'b1;
    wr(`OC_ADDR_CON1, 32'h0000_3c00);
    wr(`OC_ADDR_TMR, 32'h0000_0033);
    wait_clk(20);
    rd(`OC_ADDR_TMR, 32'h0000_ffff, 32'h0000_0033, 1'b0, 1'b0);
    wr(`OC_ADDR_CON1, 32'h0000_1c00);
    wait_clk(20);
    rd(`OC_ADDR_TMR, 32'h0000_ffff, 32'h0000_0033, 1'b0, 1'b1);
    wr(`OC_ADDR_CON2, 32'h0);
    wr(`OC_ADDR_PRI, 32'h0000_0005);
    wr(`OC_ADDR_SEC, 32'h0000_0014);
    wr(`OC_ADDR_TMR, 32'h0);
    wait_clk(40);
    rd(`OC_ADDR_CON2, 32'h0000_0040, 32'h0000_0040, 1'b0, 1'b0);
    rd(`OC_ADDR_ISTAT, 32'h0000_0008, 32'h0000_0008, 1'b0, 1'b0);
    wr(`OC_ADDR_CON1, 32'h0000_1c08);
    wr(`OC_ADDR_TMR, 32'h0);
    wait_clk(40);
    rd(`OC_ADDR_CON2, 32'h0000_0040, 32'h0, 1'b0, 1'b0);
    // pwm: period is secondary+1 = 21 ticks, high while timer < primary
    wr(`OC_ADDR_CON2, 32'h0000_0001);
    wr(`OC_ADDR_TMR, 32'h0);
    wait_clk(4);
    count_high(84, high_cnt);
    check("pwm high cycles", high_cnt, 32'h0000_0014);
    wr(`OC_ADDR_PRI, 32'h0000_000a);
    rd(`OC_ADDR_PRI, 32'h0000_ffff, 32'h0000_000a, 1'b0, 1'b0);
    // new primary only applies from the next period start
    wait_clk(24);
    count_high(84, high_cnt);
    check("pwm high cycles", high_cnt, 32'h0000_0028);
    cpu_idle <= 1'b0;
    run <= 5'h00;
    wr(`OC_ADDR_CON1, 32'h0);
    wr(`OC_ADDR_TMR, 32'h0);
    wr(`OC_ADDR_ISTAT, 32'h0000_001f);
    wr(`OC_ADDR_IMASK, 32'h0000_0001);
    // only fault A is unmasked, so irq follows fault A alone
    for (int i = 0; i < 3; i++) begin
      flt <= 3'h1 << i;
      wr(`OC_ADDR_CON1, 32'h80 << i);
      wait_clk(8);
      rd(`OC_ADDR_CON1, 32'hffff, (32'h80 << i) | (32'h10 << i), 1'b0, 1'b0);
      rd(`OC_ADDR_ISTAT, 32'h7, 32'h1 << i, 1'b0, 1'b0);
      check("irq", {31'h0, irq}, {31'h0, i == 0});
      check("compare_out", {31'h0, compare_out}, 32'h0);
      wr(`OC_ADDR_CON1, 32'h0);
      wait_clk(8);
      rd(`OC_ADDR_CON1, 32'hffff, 32'h0, 1'b0, 1'b0);
      check("compare_out", {31'h0, compare_out}, 32'h1);
      wr(`OC_ADDR_ISTAT, 32'h1 << i);
      rd(`OC_ADDR_ISTAT, 32'h7, 32'h0, 1'b0, 1'b0);
      check("irq", {31'h0, irq}, 32'h0);
      flt <= 3'h0;
      wait_clk(8);
    end
    wait_clk(4);
    stop_test();
  end
endmodule : tb_top

// >>> hdl/oc_map.svh
// register map, field positions, reset values and counts of the compare channel
`ifndef OC_MAP_SVH
`define OC_MAP_SVH
`define OC_ADDR_CON1 12'h000
`define OC_ADDR_CON2 12'h004
`define OC_ADDR_PRI 12'h008
`define OC_ADDR_SEC 12'h00c
`define OC_ADDR_TMR 12'h010
`define OC_ADDR_ISTAT 12'h014
`define OC_ADDR_IMASK 12'h018
`define OC_BIT_IDLE 13
`define OC_BIT_CSEL 10
`define OC_BIT_ENC 9
`define OC_BIT_ENB 8
`define OC_BIT_ENA 7
`define OC_BIT_STC 6
`define OC_BIT_STB 5
`define OC_BIT_STA 4
`define OC_BIT_TRIGGER_CLEAR_MODE 3
`define OC_BIT_TRIGGER_STATUS_FLAG 6
`define OC_BIT_PWM 0
`define OC_CON1_WMASK 16'h3ff8
`define OC_CON1_RESET 16'h0000
`define OC_IRQ_FA 0
`define OC_IRQ_FB 1
`define OC_IRQ_FC 2
`define OC_IRQ_TRIG 3
`define OC_IRQ_MATCH 4
`define OC_IRQ_W 5
`define OC_PIN_W 8
`endif

// >>> hdl/oc_pin_sync.sv
// two-stage synchroniser for the timer clock and fault pins
`timescale 1ns/100ps
module oc_pin_sync (
  input wire logic clk,
  input wire logic nrst,
  oc_sync_if.sync pins
);
  oc_pkg::sync_state_t s;
  oc_pkg::sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = pins.raw;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pins.synced = s.s2;
endmodule : oc_pin_sync

// >>> hdl/oc_pkg.sv
// types shared by the compare channel modules
package oc_pkg;
  typedef enum logic [2:0] {
    CS_T2 = 3'b000,
    CS_T3 = 3'b001,
    CS_T4 = 3'b010,
    CS_T5 = 3'b011,
    CS_T1 = 3'b100,
    CS_RSV5 = 3'b101,
    CS_RSV6 = 3'b110,
    CS_PCLK = 3'b111
  } clk_sel_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } sync_state_t;

  typedef struct packed {
    logic [15:0] con1;
    logic trig_stat;
    logic pwm_mode;
    logic [15:0] pri;
    logic [15:0] sec;
    logic [15:0] pri_buf;
    logic [15:0] sec_buf;
    logic [15:0] timer;
    logic [4:0] clk_prev;
    logic [4:0] istat;
    logic [4:0] imask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic cmp_out;
  } top_state_t;
endpackage : oc_pkg

// >>> hdl/oc_sync_if.sv
// raw and synchronised pin levels between the channel and its synchroniser
`timescale 1ns/100ps
interface oc_sync_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport owner (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : oc_sync_if

// >>> hdl/output_compare_control.sv
// compare channel control: first control register, fault inputs, trigger flag, APB slave
//
// Register access over APB and the register addresses were chosen for this implementation.
`include "oc_map.svh"
`timescale 1ns/100ps
module output_compare_control #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic cpu_idle,
  input wire logic timer1_clock_source,
  input wire logic timer2_clock_source,
  input wire logic timer3_clock_source,
  input wire logic timer4_clock_source,
  input wire logic timer5_clock_source,
  input wire logic fault_a_pin,
  input wire logic fault_b_pin,
  input wire logic fault_c_pin,
  output logic compare_out
);
  oc_pkg::top_state_t s;
  oc_pkg::top_state_t next_s;
  oc_sync_if pins ();

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  assign pins.raw = {fault_c_pin, fault_b_pin, fault_a_pin, timer5_clock_source,
                     timer4_clock_source, timer3_clock_source, timer2_clock_source,
                     timer1_clock_source};

  oc_pin_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .pins(pins)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : lane_merge

  logic [4:0] rise;
  logic tick;
  logic halted;
  logic run;
  logic setup;
  logic wr;
  logic [AW-1:0] a;
  logic mapped;
  logic [31:0] rd;
  logic [2:0] en;
  logic [2:0] fpin;
  logic [15:0] wv;
  logic period_hit;
  logic pri_hit;
  oc_pkg::clk_sel_t csel;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    a = paddr;
    setup = psel && !penable;
    wr = psel && penable && s.pready && pwrite;
    csel = oc_pkg::clk_sel_t'(s.con1[`OC_BIT_CSEL+2:`OC_BIT_CSEL]);
    rise = pins.synced[4:0] & ~s.clk_prev;
    next_s.clk_prev = pins.synced[4:0];
    en = {s.con1[`OC_BIT_ENC], s.con1[`OC_BIT_ENB], s.con1[`OC_BIT_ENA]};
    fpin = pins.synced[7:5];
    period_hit = s.timer == s.sec;
    pri_hit = s.timer == s.pri;
    wv = 16'h0000;
    // timer clocks arrive as levels; count on their rising edge
    case (csel)
      oc_pkg::CS_T2: tick = rise[1];
      oc_pkg::CS_T3: tick = rise[2];
      oc_pkg::CS_T4: tick = rise[3];
      oc_pkg::CS_T5: tick = rise[4];
      oc_pkg::CS_T1: tick = rise[0];
      oc_pkg::CS_PCLK: tick = 1'b1;
      // reserved selections leave the channel unclocked
      default: tick = 1'b0;
    endcase
    halted = s.con1[`OC_BIT_IDLE] && cpu_idle;
    run = tick && !halted;

    // channel time base
    if (run) begin
      if (s.pwm_mode && period_hit) begin
        next_s.timer = 16'h0000;
        next_s.pri = s.pri_buf;
        next_s.sec = s.sec_buf;
      end else begin
        next_s.timer = s.timer + 16'h0001;
      end
      if (pri_hit) begin
        if (!s.pwm_mode) begin
          next_s.cmp_out = ~s.cmp_out;
        end
      end
    end

    // register reads are captured in the setup cycle
    mapped = 1'b1;
    rd = 32'h0000_0000;
    case (a)
      `OC_ADDR_CON1: rd[15:0] = s.con1 & `OC_CON1_WMASK;
      `OC_ADDR_CON2: begin
        rd[`OC_BIT_TRIGGER_STATUS_FLAG] = s.trig_stat;
        rd[`OC_BIT_PWM] = s.pwm_mode;
      end
      `OC_ADDR_PRI: rd[15:0] = s.pwm_mode ? s.pri_buf : s.pri;
      `OC_ADDR_SEC: rd[15:0] = s.pwm_mode ? s.sec_buf : s.sec;
      `OC_ADDR_TMR: rd[15:0] = s.timer;
      `OC_ADDR_ISTAT: rd[`OC_IRQ_W-1:0] = s.istat;
      `OC_ADDR_IMASK: rd[`OC_IRQ_W-1:0] = s.imask;
      default: mapped = 1'b0;
    endcase
    next_s.pready = setup;
    next_s.pslverr = setup && !mapped;
    if (setup) begin
      next_s.prdata = mapped ? rd : 32'h0000_0000;
    end

    // software writes
    if (wr) begin
      case (a)
        `OC_ADDR_CON1: begin
          wv = lane_merge(s.con1, pwdata, pstrb);
          next_s.con1 = wv & `OC_CON1_WMASK;
        end
        `OC_ADDR_CON2: begin
          if (pstrb[0]) begin
            next_s.trig_stat = pwdata[`OC_BIT_TRIGGER_STATUS_FLAG];
            next_s.pwm_mode = pwdata[`OC_BIT_PWM];
          end
        end
        `OC_ADDR_PRI: begin
          wv = lane_merge(s.pri_buf, pwdata, pstrb);
          next_s.pri_buf = wv;
          if (!s.pwm_mode) begin
            next_s.pri = wv;
          end
        end
        `OC_ADDR_SEC: begin
          wv = lane_merge(s.sec_buf, pwdata, pstrb);
          next_s.sec_buf = wv;
          if (!s.pwm_mode) begin
            next_s.sec = wv;
          end
        end
        `OC_ADDR_TMR: next_s.timer = lane_merge(s.timer, pwdata, pstrb);
        `OC_ADDR_ISTAT: begin
          if (pstrb[0]) begin
            next_s.istat = s.istat & ~pwdata[`OC_IRQ_W-1:0];
          end
        end
        `OC_ADDR_IMASK: begin
          if (pstrb[0]) begin
            next_s.imask = pwdata[`OC_IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // trigger flag: hardware clear, then set, so a set in the same cycle wins
    if (s.con1[`OC_BIT_TRIGGER_CLEAR_MODE] && period_hit) begin
      next_s.trig_stat = 1'b0;
    end
    // event sets come after the software clear so a set in the same cycle wins
    if (run && pri_hit) begin
      next_s.trig_stat = 1'b1;
      next_s.istat[`OC_IRQ_TRIG] = 1'b1;
      next_s.istat[`OC_IRQ_MATCH] = 1'b1;
    end

    // fault status: disabling an input clears it; an enabled pin sets it
    if (!next_s.con1[`OC_BIT_ENA]) begin
      next_s.con1[`OC_BIT_STA] = 1'b0;
    end
    if (!next_s.con1[`OC_BIT_ENB]) begin
      next_s.con1[`OC_BIT_STB] = 1'b0;
    end
    if (!next_s.con1[`OC_BIT_ENC]) begin
      next_s.con1[`OC_BIT_STC] = 1'b0;
    end
    if (en[0] && fpin[0]) begin
      next_s.con1[`OC_BIT_STA] = 1'b1;
    end
    if (en[1] && fpin[1]) begin
      next_s.con1[`OC_BIT_STB] = 1'b1;
    end
    if (en[2] && fpin[2]) begin
      next_s.con1[`OC_BIT_STC] = 1'b1;
    end
    if (next_s.con1[`OC_BIT_STA] && !s.con1[`OC_BIT_STA]) begin
      next_s.istat[`OC_IRQ_FA] = 1'b1;
    end
    if (next_s.con1[`OC_BIT_STB] && !s.con1[`OC_BIT_STB]) begin
      next_s.istat[`OC_IRQ_FB] = 1'b1;
    end
    if (next_s.con1[`OC_BIT_STC] && !s.con1[`OC_BIT_STC]) begin
      next_s.istat[`OC_IRQ_FC] = 1'b1;
    end

    // output: PWM level, forced low while an enabled fault is latched
    if (s.pwm_mode) begin
      next_s.cmp_out = next_s.timer < next_s.pri;
    end
    if (|(next_s.con1[`OC_BIT_STC:`OC_BIT_STA] &
          {next_s.con1[`OC_BIT_ENC], next_s.con1[`OC_BIT_ENB], next_s.con1[`OC_BIT_ENA]})) begin
      next_s.cmp_out = 1'b0;
    end
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign compare_out = s.cmp_out;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_idle_halt;
    (s.con1[`OC_BIT_IDLE] && cpu_idle && !wr) |=> (s.timer == $past(s.timer));
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("timer moved during idle halt");

  property p_pclk_count;
    (csel == oc_pkg::CS_PCLK && !halted && !wr && !s.pwm_mode) |=> (s.timer == $past(s.timer) + 16'h0001);
  endproperty
  a_pclk_count: assert property (p_pclk_count) else $error("timer missed a peripheral tick");

  property p_t2_gate;
    (csel == oc_pkg::CS_T2 && !rise[1] && !wr) |=> (s.timer == $past(s.timer));
  endproperty
  a_t2_gate: assert property (p_t2_gate) else $error("timer moved without timer 2 edge");

  property p_t1_count;
    (csel == oc_pkg::CS_T1 && rise[0] && !halted && !wr && !s.pwm_mode)
      |=> (s.timer == $past(s.timer) + 16'h0001);
  endproperty
  a_t1_count: assert property (p_t1_count) else $error("timer missed a timer 1 edge");

  property p_fault_c_off;
    (!s.con1[`OC_BIT_ENC] && !wr) |=> !s.con1[`OC_BIT_STC];
  endproperty
  a_fault_c_off: assert property (p_fault_c_off) else $error("disabled fault C set status");

  property p_fault_b_set;
    (s.con1[`OC_BIT_ENB] && pins.synced[6])
      |=> s.con1[`OC_BIT_STB] && (s.istat[`OC_IRQ_FB] || $past(s.con1[`OC_BIT_STB]));
  endproperty
  a_fault_b_set: assert property (p_fault_b_set) else $error("fault B not latched");

  property p_fault_a_set;
    (s.con1[`OC_BIT_ENA] && pins.synced[5]) |=> s.con1[`OC_BIT_STA];
  endproperty
  a_fault_a_set: assert property (p_fault_a_set) else $error("fault A not latched");

  property p_fault_out;
    (s.con1[`OC_BIT_STA] && s.con1[`OC_BIT_ENA]) |-> !compare_out;
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("output high during fault");

  property p_trig_hw_clear;
    (s.con1[`OC_BIT_TRIGGER_CLEAR_MODE] && period_hit && !(run && pri_hit)) |=> !s.trig_stat;
  endproperty
  a_trig_hw_clear: assert property (p_trig_hw_clear) else $error("trigger flag not cleared");

  property p_trig_sw_only;
    (!s.con1[`OC_BIT_TRIGGER_CLEAR_MODE] && s.trig_stat && !(wr && a == `OC_ADDR_CON2)) |=> s.trig_stat;
  endproperty
  a_trig_sw_only: assert property (p_trig_sw_only) else $error("trigger flag cleared by hardware");

  property p_pwm_buffer;
    (s.pwm_mode && wr && a == `OC_ADDR_PRI && !(run && period_hit)) |=> (s.pri == $past(s.pri));
  endproperty
  a_pwm_buffer: assert property (p_pwm_buffer) else $error("primary not buffered in pwm mode");

  property p_con1_top;
    (setup && a == `OC_ADDR_CON1) |=> (prdata[31:14] == 18'h00000) && pready;
  endproperty
  a_con1_top: assert property (p_con1_top) else $error("unimplemented bits read nonzero");

  c_fault_latch: cover property (s.con1[`OC_BIT_ENA] && pins.synced[5] ##1 s.con1[`OC_BIT_STA]);
  c_trig_clear: cover property (s.trig_stat ##1 !s.trig_stat);
  c_pwm_reload: cover property (s.pwm_mode && run && period_hit);
  c_irq: cover property (!irq ##1 irq);
endmodule : output_compare_control
